//--- bench/stid_jtag_model.sv
// Purpose: Board-level test controller driving the test clock, mode and data pins.
// Assumes: The port sits in Run-Test/Idle between frames.
// Notes: The test clock stands still low between frames.
`timescale 1ns/10ps
`default_nettype none
module stid_jtag_model (
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i
);
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // One 125 ns test-clock period; mode and data lead the rise by half a period
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #62.5;
        tdo = tdo_i;
        tck_o = 1'b1;
        // A data line past its hold time must not keep showing the old bit
        #31.25;
        tdi_o = ~tdi;
        #31.25;
        tck_o = 1'b0;
    endtask

    // Only implemented codes are ever issued
    task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
        logic       t;
        logic [3:0] hdr;
        hdr = 4'h3;
        for (int i = 0; i < 4; i++)
            step(hdr[i], 1'b0, t);
        for (int i = 0; i < 3; i++)
            step(i == 2, code[i], cap[i]);
        step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
    endtask

    task automatic scan_dr(input int n, input logic [89:0] din, output logic [89:0] dout);
        logic t;
        dout = '0;
        step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
        step(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++)
            step(i == n - 1, din[i], dout[i]);
        step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
    endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Purpose: Self-checking bench for the SRAM test access port decode.
// Assumes: Controller model owns the test pins; bench owns reset and ring.
// Notes: Every scan starts and ends in Run-Test/Idle.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import stid_pkg::*;
    localparam logic [89:0] PAT = 90'h2_5A5A_C3C3_0F0F_9999_1234;
    logic             core_clk_i;
    logic             rst_i;
    logic             tck;
    logic             tms;
    logic             tdi;
    logic             tdo_o;
    logic             tdo_oe_o;
    logic             mem_out_hiz_o;
    logic [BSR_W-1:0] ring_i;
    logic [IR_W-1:0]  instr_o;
    logic [2:0]       cap;
    logic [89:0]      dout;
    logic             t;
    int               n_fail;
    int               n_compared;
    int               n_oe;

    stid_tap_top i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .ring_i(ring_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
        .mem_out_hiz_o(mem_out_hiz_o), .instr_o(instr_o));
    stid_jtag_model i_ctrl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_o));

    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // Core cycles with the data output driven, to see that the enable spans the whole shift
    always @(posedge core_clk_i)
        if (tdo_oe_o === 1'b1)
            n_oe++;

    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic test_done();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic t_reset();
        check(instr_o === INS_IDENT, "reset instruction");
        check(mem_out_hiz_o === 1'b0 && tdo_oe_o === 1'b0, "reset outputs");
        i_ctrl.step(1'b0, 1'b0, t);
        i_ctrl.scan_dr(32, '0, dout);
        check(dout[31:0] === ID_VALUE, "id after reset");
        check(tdo_oe_o === 1'b0, "tdo enable idle");
    endtask

    task automatic t_ident();
        int oe_base;
        i_ctrl.load_ir(INS_IDENT, cap);
        check(cap[1:0] === 2'h1, "ir capture pattern");
        oe_base = n_oe;
        i_ctrl.scan_dr(32, {58'h0, 32'hFFFF_FFFF}, dout);
        // 32 test-clock periods of 12.5 core cycles, one cycle of slack for sampling phase
        check(n_oe - oe_base >= 399 && n_oe - oe_base <= 401, "tdo enable in shift");
        check(dout[31:0] === ID_VALUE, "id value");
        check(dout[0] === 1'b1, "id presence bit");
        check(mem_out_hiz_o === 1'b0, "id leaves memory");
    endtask

    task automatic t_bypass();
        i_ctrl.load_ir(INS_BYPASS, cap);
        check(instr_o === INS_BYPASS, "bypass current");
        i_ctrl.scan_dr(8, {82'h0, 8'hA5}, dout);
        check(dout[7:0] === 8'h4A, "bypass path");
        check(mem_out_hiz_o === 1'b0, "bypass leaves memory");
    endtask

    task automatic t_ring();
        logic [8:0] codes;
        logic [2:0] hiz;
        codes = {INS_SAMPLE, INS_SAMPLE_HIZ, INS_RING_HIZ};
        hiz = 3'h3;
        for (int i = 0; i < 3; i++)
        begin
            @(negedge core_clk_i);
            ring_i = {PAT[89:3], codes[3*i +: 3]};
            i_ctrl.load_ir(codes[3*i +: 3], cap);
            check(instr_o === codes[3*i +: 3], "ring instruction");
            check(mem_out_hiz_o === hiz[i], "ring high-z");
            i_ctrl.scan_dr(90, '0, dout);
            check(dout === ring_i, "ring capture");
        end
    endtask

    task automatic t_tlr();
        i_ctrl.load_ir(INS_RING_HIZ, cap);
        for (int i = 0; i < 5; i++)
            i_ctrl.step(1'b1, 1'b0, t);
        i_ctrl.step(1'b0, 1'b0, t);
        check(instr_o === INS_IDENT && mem_out_hiz_o === 1'b0, "tlr select id");
    endtask

    task automatic t_rst();
        i_ctrl.load_ir(INS_SAMPLE_HIZ, cap);
        @(negedge core_clk_i);
        rst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        check(instr_o === INS_IDENT && mem_out_hiz_o === 1'b0, "mid-run reset");
        i_ctrl.step(1'b0, 1'b0, t);
        i_ctrl.load_ir(INS_BYPASS, cap);
        check(instr_o === INS_BYPASS, "load after reset");
    endtask

    // Ceiling well above the roughly 5700 core cycles the scans need
    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        n_fail++;
        test_done();
    end

    initial
    begin
        n_fail = 0;
        n_compared = 0;
        rst_i = 1'b1;
        ring_i = PAT;
        repeat (8) @(negedge core_clk_i);
        rst_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        t_reset();
        t_ident();
        t_bypass();
        t_ring();
        t_tlr();
        t_rst();
        test_done();
    end
endmodule
`default_nettype wire

//--- hw/stid_pin_sync.sv
// Purpose: Brings the test clock, mode and data pins into the core clock domain.
// Assumes: Core clock at least eight times the test clock.
// Notes: Edge pulses last one core cycle; mode and data share the clock's latency.
`timescale 1ns/10ps
`default_nettype none
module stid_pin_sync
    import stid_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic tck_i,
    input  wire logic tms_i,
    input  wire logic tdi_i,
    output logic      tck_rise_o,
    output logic      tck_fall_o,
    output logic      tms_o,
    output logic      tdi_o
);

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic       tck_prev;
    } stid_sync_t;

    stid_sync_t sync_r;
    stid_sync_t sync_nxt;

    always_comb
    begin
        sync_nxt          = sync_r;
        sync_nxt.s1       = {tdi_i, tms_i, tck_i};
        sync_nxt.s2       = sync_r.s1;
        sync_nxt.tck_prev = sync_r.s2[0];
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            sync_r <= '0;
        else
            sync_r <= sync_nxt;
    end

    // Only the second stage and its delayed copy tck_prev are looked at
    assign tck_rise_o = sync_r.s2[0] & ~sync_r.tck_prev;
    assign tck_fall_o = ~sync_r.s2[0] & sync_r.tck_prev;
    assign tms_o      = sync_r.s2[1];
    assign tdi_o      = sync_r.s2[2];

endmodule
`default_nettype wire

//--- hw/stid_pkg.sv
// Purpose: Constants, types and decode functions for the SRAM test access port.
// Assumes: Three-bit instruction register and 32-bit identification register.
// Notes on behaviour
// R1 - With 111 current, the one-bit bypass register sits between TDI and TDO in Shift-DR.
// R2 - The test controller never loads 011, 101 or 110; here they fall back to bypass.
// R3 - Code 000 captures the I/O ring into the scan chain and forces memory outputs to high-Z.
// R4 - Code 001 loads the identification value and shifts it out, memory left alone.
// R5 - Code 010 captures the I/O ring into the scan chain and forces output drivers to high-Z.
// R6 - Code 100 captures the I/O ring into the scan chain and never drives preloaded values.
// R7 - Instructions shift in during Shift-IR and only take effect at Update-IR.
// R8 - Reset and the test-logic-reset state both select the identification instruction.
// R9 - Capture-IR loads binary 01 into the two low instruction register bits.
// R10 - The identification register is 32 bits with a hardwired value whose bit 0 is 1.
// R11 - The sixteen-state controller moves on rising test-clock edges and TDO changes on falling.
package stid_pkg;

    localparam int IR_W  = 3;
    localparam int ID_W  = 32;
    localparam int BSR_W = 90;

    localparam logic [2:0] INS_RING_HIZ   = 3'h0;
    localparam logic [2:0] INS_IDENT      = 3'h1;
    localparam logic [2:0] INS_SAMPLE_HIZ = 3'h2;
    localparam logic [2:0] INS_SAMPLE     = 3'h4;
    localparam logic [2:0] INS_BYPASS     = 3'h7;
    localparam logic [2:0] IR_CAPTURE     = 3'h1;

    localparam logic       BYP_CAPTURE = 1'h0;

    // Revision, device and maker fields are arbitrary values
    localparam logic [3:0]  ID_REV     = 4'h0;
    localparam logic [4:0]  ID_DEPTH   = 5'h09;
    localparam logic [4:0]  ID_WIDTH   = 5'h04;
    localparam logic [5:0]  ID_DEV     = 6'h00;
    localparam logic [10:0] ID_MAKER   = 11'h2C3;
    localparam logic        ID_PRESENT = 1'h1;
    localparam logic [31:0] ID_VALUE   = {ID_REV, ID_DEPTH, ID_WIDTH, ID_DEV, ID_MAKER, ID_PRESENT};

    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
        ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } stid_tap_state_t;

    typedef enum logic [1:0] {DR_BYPASS, DR_IDENT, DR_RING} stid_dr_sel_t;

    function automatic stid_dr_sel_t stid_dr_select(input logic [2:0] ins);
        case (ins)
            INS_RING_HIZ, INS_SAMPLE_HIZ, INS_SAMPLE: stid_dr_select = DR_RING;
            INS_IDENT:                                stid_dr_select = DR_IDENT;
            default:                                  stid_dr_select = DR_BYPASS;
        endcase
    endfunction

    function automatic logic stid_hiz_of(input logic [2:0] ins);
        stid_hiz_of = (ins == INS_RING_HIZ) || (ins == INS_SAMPLE_HIZ);
    endfunction

    function automatic stid_tap_state_t stid_tap_next(input stid_tap_state_t st, input logic tms);
        case (st)
            ST_TLR:    stid_tap_next = tms ? ST_TLR    : ST_RTI;
            ST_RTI:    stid_tap_next = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: stid_tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: stid_tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  stid_tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: stid_tap_next = tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  stid_tap_next = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: stid_tap_next = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: stid_tap_next = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: stid_tap_next = tms ? ST_TLR    : ST_CAP_IR;
            ST_CAP_IR: stid_tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  stid_tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: stid_tap_next = tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  stid_tap_next = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: stid_tap_next = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: stid_tap_next = tms ? ST_SEL_DR : ST_RTI;
            default:   stid_tap_next = ST_TLR;
        endcase
    endfunction

endpackage

//--- hw/stid_tap_top.sv
// Purpose: Test access port with instruction decode for a synchronous SRAM.
// Assumes: ring_i is already sampled on core_clk_i by the pad logic.
// Notes: The test clock is sampled, so it must stay well below core_clk_i / 8.
`timescale 1ns/10ps
`default_nettype none
module stid_tap_top
    import stid_pkg::*;
(
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    input  wire logic             tck_i,
    input  wire logic             tms_i,
    input  wire logic             tdi_i,
    input  wire logic [BSR_W-1:0] ring_i,
    output logic                  tdo_o,
    output logic                  tdo_oe_o,
    output logic                  mem_out_hiz_o,
    output logic [IR_W-1:0]       instr_o
);

    typedef struct packed {
        stid_tap_state_t  st;
        logic [IR_W-1:0]  ir_sh;
        logic [IR_W-1:0]  ir_cur;
        logic             byp;
        logic [ID_W-1:0]  id_sh;
        logic [BSR_W-1:0] bsr;
        logic             tdo;
        logic             tdo_oe;
        logic             hiz;
    } stid_tap_t;

    stid_tap_t    tap_r;
    stid_tap_t    tap_nxt;
    logic         tck_rise;
    logic         tck_fall;
    logic         tms_s;
    logic         tdi_s;
    stid_dr_sel_t sel;

    stid_pin_sync u_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .tck_i      (tck_i),
        .tms_i      (tms_i),
        .tdi_i      (tdi_i),
        .tck_rise_o (tck_rise),
        .tck_fall_o (tck_fall),
        .tms_o      (tms_s),
        .tdi_o      (tdi_s)
    );

    // Unused codes route to bypass so the chain length stays defined
    assign sel = stid_dr_select(tap_r.ir_cur); // [R2]

    always_comb
    begin
        tap_nxt = tap_r;
        if (tck_rise)
        begin
            tap_nxt.st = stid_tap_next(tap_r.st, tms_s); // [R11]
            case (tap_r.st)
                ST_CAP_IR: tap_nxt.ir_sh = IR_CAPTURE; // [R9]
                ST_SH_IR:  tap_nxt.ir_sh = {tdi_s, tap_r.ir_sh[IR_W-1:1]}; // [R7]
                ST_CAP_DR:
                begin
                    case (sel)
                        DR_IDENT:  tap_nxt.id_sh = ID_VALUE; // [R4] [R10]
                        DR_RING:   tap_nxt.bsr   = ring_i; // [R3] [R5] [R6]
                        default:   tap_nxt.byp   = BYP_CAPTURE; // [R1]
                    endcase
                end
                ST_SH_DR:
                begin
                    case (sel)
                        DR_IDENT:  tap_nxt.id_sh = {tdi_s, tap_r.id_sh[ID_W-1:1]}; // [R4]
                        DR_RING:   tap_nxt.bsr   = {tdi_s, tap_r.bsr[BSR_W-1:1]}; // [R6]
                        default:   tap_nxt.byp   = tdi_s; // [R1]
                    endcase
                end
                default: ;
            endcase
        end
        if (tck_fall)
        begin
            // Update-DR applies nothing: preloaded values never reach the pins
            if (tap_r.st == ST_UPD_IR)
                tap_nxt.ir_cur = tap_r.ir_sh; // [R7]
            tap_nxt.tdo_oe = (tap_r.st == ST_SH_IR) || (tap_r.st == ST_SH_DR); // [R11]
            case (tap_r.st)
                ST_SH_IR: tap_nxt.tdo = tap_r.ir_sh[0];
                ST_SH_DR:
                begin
                    case (sel)
                        DR_IDENT: tap_nxt.tdo = tap_r.id_sh[0];
                        DR_RING:  tap_nxt.tdo = tap_r.bsr[0];
                        default:  tap_nxt.tdo = tap_r.byp; // [R1]
                    endcase
                end
                default:  tap_nxt.tdo = 1'b0;
            endcase
        end
        if (tap_r.st == ST_TLR)
            tap_nxt.ir_cur = INS_IDENT; // [R8]
        tap_nxt.hiz = stid_hiz_of(tap_nxt.ir_cur); // [R3] [R5]
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tap_r        <= '0;
            tap_r.st     <= ST_TLR;
            tap_r.ir_cur <= INS_IDENT; // [R8]
        end
        else
            tap_r <= tap_nxt;
    end

    assign tdo_o         = tap_r.tdo;
    assign tdo_oe_o      = tap_r.tdo_oe;
    assign mem_out_hiz_o = tap_r.hiz;
    assign instr_o       = tap_r.ir_cur;

    property p_fsm_step;
        @(posedge core_clk_i) disable iff (rst_i)
        tck_rise |=> tap_r.st == stid_tap_next($past(tap_r.st), $past(tms_s));
    endproperty
    a_fsm_step: assert property (p_fsm_step) // [R11]
        else $error("TAP state did not follow mode select");

    property p_fsm_hold;
        @(posedge core_clk_i) disable iff (rst_i)
        !tck_rise |=> $stable(tap_r.st);
    endproperty
    a_fsm_hold: assert property (p_fsm_hold) // [R11]
        else $error("TAP state moved without a rising test clock");

    property p_tdo_on_fall;
        @(posedge core_clk_i) disable iff (rst_i)
        !$stable(tdo_o) |-> $past(tck_fall);
    endproperty
    a_tdo_on_fall: assert property (p_tdo_on_fall) // [R11]
        else $error("TDO changed away from a falling test clock");

    property p_ir_capture;
        @(posedge core_clk_i) disable iff (rst_i)
        tck_rise && tap_r.st == ST_CAP_IR |=> tap_r.ir_sh[1:0] == 2'h1;
    endproperty
    a_ir_capture: assert property (p_ir_capture) // [R9]
        else $error("Capture-IR did not load 01");

    property p_ir_change;
        @(posedge core_clk_i) disable iff (rst_i)
        !$stable(instr_o) |-> ($past(tap_r.st) == ST_UPD_IR && $past(tck_fall))
                              || $past(tap_r.st) == ST_TLR;
    endproperty
    a_ir_change: assert property (p_ir_change) // [R7]
        else $error("Instruction changed outside Update-IR");

    property p_tlr_ident;
        @(posedge core_clk_i) disable iff (rst_i)
        tap_r.st == ST_TLR |=> instr_o == INS_IDENT;
    endproperty
    a_tlr_ident: assert property (p_tlr_ident) // [R8]
        else $error("Test-logic-reset did not select identification");

    property p_id_capture;
        @(posedge core_clk_i) disable iff (rst_i)
        tck_rise && tap_r.st == ST_CAP_DR && sel == DR_IDENT
        |=> tap_r.id_sh == ID_VALUE && tap_r.id_sh[0];
    endproperty
    a_id_capture: assert property (p_id_capture) // [R10]
        else $error("Identification capture wrong");

    property p_byp_path;
        @(posedge core_clk_i) disable iff (rst_i)
        tck_rise && tap_r.st == ST_SH_DR && instr_o == INS_BYPASS |=> tap_r.byp == $past(tdi_s);
    endproperty
    a_byp_path: assert property (p_byp_path) // [R1]
        else $error("Bypass bit did not take TDI");

    property p_ring_capture;
        @(posedge core_clk_i) disable iff (rst_i)
        tck_rise && tap_r.st == ST_CAP_DR && instr_o == INS_SAMPLE |=> tap_r.bsr == $past(ring_i);
    endproperty
    a_ring_capture: assert property (p_ring_capture) // [R6]
        else $error("Ring capture wrong");

    property p_hiz_ring;
        @(posedge core_clk_i) disable iff (rst_i)
        tck_fall && tap_r.st == ST_UPD_IR && tap_r.ir_sh == INS_RING_HIZ |=> mem_out_hiz_o;
    endproperty
    a_hiz_ring: assert property (p_hiz_ring) // [R3]
        else $error("Code 000 did not force high-Z");

    property p_hiz_sample;
        @(posedge core_clk_i) disable iff (rst_i)
        tck_fall && tap_r.st == ST_UPD_IR && tap_r.ir_sh == INS_SAMPLE_HIZ |=> mem_out_hiz_o;
    endproperty
    a_hiz_sample: assert property (p_hiz_sample) // [R5]
        else $error("Code 010 did not force high-Z");

    property p_no_hiz;
        @(posedge core_clk_i) disable iff (rst_i)
        instr_o == INS_SAMPLE || instr_o == INS_IDENT || instr_o == INS_BYPASS |-> !mem_out_hiz_o;
    endproperty
    a_no_hiz: assert property (p_no_hiz) // [R4]
        else $error("High-Z forced by a non-intrusive code");

    property p_cov_bypass;
        @(posedge core_clk_i) disable iff (rst_i)
        tck_fall && tap_r.st == ST_UPD_IR && tap_r.ir_sh == INS_BYPASS;
    endproperty
    c_cov_bypass: cover property (p_cov_bypass);

    property p_cov_id_shift;
        @(posedge core_clk_i) disable iff (rst_i)
        tdo_oe_o && tap_r.st == ST_SH_DR && sel == DR_IDENT;
    endproperty
    c_cov_id_shift: cover property (p_cov_id_shift);

    property p_cov_hiz;
        @(posedge core_clk_i) disable iff (rst_i)
        $rose(mem_out_hiz_o);
    endproperty
    c_cov_hiz: cover property (p_cov_hiz);

    property p_cov_ring_shift;
        @(posedge core_clk_i) disable iff (rst_i)
        tck_rise && tap_r.st == ST_SH_DR && sel == DR_RING;
    endproperty
    c_cov_ring_shift: cover property (p_cov_ring_shift);

endmodule
`default_nettype wire
